//--- dwgpc_pkg.sv
// Constants, field layout and enumerations for the deep-well pad configuration block
// Contract
// - Twelve event enable bits 11:0, reset zero; set bit lets status raise an event.
// - An event is raised only when the pad also routes to SCI.
// - Field 31:30 picks which reset clears the pad configuration fields.
// - Host deep reset follows host reset, global reset or deep sleep entry.
// - Bit 29 picks raw or processed receive state for native functions.
// - Bit 28 forces the received state to one, ahead of inversion.
// - Field 26:25 picks level, edge, disabled or any-edge event delivery.
// - Event delivery never changes the received state seen by software or functions.
// - Bit 24 picks unfiltered or glitch-filtered synchronized receive state.
// - Bit 23 inverts state toward event logic, never the software receive bit.
// - In native mode field 22:21 sets the receive buffer enable and forced receive levels.
// - In GPIO mode the two disable bits control the pad buffers.
// - Bit 20 gates only the peripheral IRQ indication of a GPIO input.
// - Bit 19 gates only the event indication to power management.
// - Bit 18 is read-only and gates the SMI indication.
// - Bit 17 is read-only; when clear NMI status is never set.
// - Bit 10 is hardware pad mode: 0 GPIO, 1 native function.
// - Bit 9 disables the input buffer in GPIO mode, holding state zero.
// - Bit 8 floats the output buffer in GPIO mode only.
// - Bit 1 reads filtered receive state, zero while bit 9 is set in either pad mode.
// - Bit 0 sets the driven pad level in GPIO mode only.
// - Sticky event status set by qualifying input, cleared by writing one.
// - Ownership steers events to event/NMI/SMI status or interrupt status.
package dwgpc_pkg;
  localparam int NPADS = 12;
  localparam int AW = 12;
  localparam logic [AW-1:0] OFS_EVT_STS = 12'h140;
  localparam logic [AW-1:0] OFS_EVT_EN = 12'h160;
  localparam logic [AW-1:0] OFS_CFG0 = 12'h700;
  localparam int B_RST_LO = 30;
  localparam int B_NAT_SEL = 29;
  localparam int B_FORCE1 = 28;
  localparam int B_EVT_LO = 25;
  localparam int B_BYPASS = 24;
  localparam int B_INV = 23;
  localparam int B_BUF_LO = 21;
  localparam int B_R_IRQ = 20;
  localparam int B_R_SCI = 19;
  localparam int B_R_SMI = 18;
  localparam int B_R_NMI = 17;
  localparam int B_FSEL = 10;
  localparam int B_RXOFF = 9;
  localparam int B_TXOFF = 8;
  localparam int B_RXLVL = 1;
  localparam int B_TXLVL = 0;
  localparam logic [31:0] CFG_WR_MASK = 32'hf7f8_0301;
  localparam logic [31:0] CFG_RST = 32'h0400_0300;
  localparam logic [NPADS-1:0] PADS_ZERO = 12'h000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int CLK_NS = 10;
  localparam int FILT_NS = 30;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {RS_DSW = 2'h0, RS_HOST_DEEP = 2'h1, RS_PLT = 2'h2, RS_RSM = 2'h3} dwgpc_rst_src_t;
  typedef enum logic [1:0] {EV_LEVEL = 2'h0, EV_EDGE = 2'h1, EV_OFF = 2'h2, EV_ANY = 2'h3} dwgpc_evt_t;
  typedef enum logic [1:0] {NB_FUNC = 2'h0, NB_RX0 = 2'h1, NB_RX1 = 2'h2, NB_RXON = 2'h3} dwgpc_nbuf_t;
endpackage

//--- dwgpc_filter.sv
// Glitch filter: output follows input only after it has been stable for a number of cycles
`timescale 1ns/1ps
`default_nettype none
module dwgpc_filter #(
  parameter int CYCLES = 3
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_din,
  output logic o_dout
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic out_q, out_d;

  // Any return to agreement restarts the count, so short pulses never pass
  always_comb
  begin
    cnt_d = CNT_ZERO;
    out_d = out_q;
    if (i_din != out_q)
    begin
      if (cnt_q >= LAST)
        out_d = i_din;
      else
        cnt_d = cnt_q + CNT_ONE;
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q <= CNT_ZERO;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign o_dout = out_q;
endmodule
`default_nettype wire

//--- dwgpc_top.sv
// Deep-well pad configuration: pad 0 receive path, buffers, event routing and registers
`timescale 1ns/1ps
`default_nettype none
module dwgpc_top #(
  parameter logic ROUTE_SMI_DEF = 1'b0,
  parameter logic ROUTE_NMI_DEF = 1'b0,
  parameter logic PAD_MODE_DEF = 1'b0,
  parameter int FILT_CYCLES = dwgpc_pkg::FILT_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [dwgpc_pkg::AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire logic i_pad_rx,
  output logic o_pad_tx,
  output logic o_pad_tx_oe,
  output logic o_pad_rx_en,
  input wire logic i_native_tx,
  input wire logic i_native_tx_en,
  output logic o_native_rx,
  input wire logic i_func_sel_we,
  input wire logic i_func_sel,
  input wire logic i_host_own,
  input wire logic [dwgpc_pkg::NPADS-1:1] i_other_evt_set,
  input wire logic [dwgpc_pkg::NPADS-1:1] i_other_route_sci,
  input wire logic i_host_rst,
  input wire logic i_global_rst,
  input wire logic i_deep_sx,
  input wire logic i_plt_rst_n,
  input wire logic i_rsm_rst_n,
  output logic o_host_deep_rst,
  output logic o_gpe,
  output logic o_int_sts_set,
  output logic o_irq,
  output logic o_smi,
  output logic o_nmi_sts_set
);
  import dwgpc_pkg::*;

  localparam int NSYNC = 6;
  localparam logic [NSYNC-1:0] SYNC_RST = 6'h00;

  logic [NSYNC-1:0] meta_q, sync_q;
  logic [31:0] cfg_q, cfg_d;
  logic fsel_q, fsel_d;
  logic [NPADS-1:0] en_q, en_d, sts_q, sts_d, sts_set, route_vec;
  logic prev_q, prev_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic tx_q, tx_d, oe_q, oe_d, rxen_q, rxen_d, nat_q, nat_d;
  logic deep_q, deep_d, gpe_q, gpe_d, int_q, int_d, irq_q, irq_d, smi_q, smi_d, nmi_q, nmi_d;
  logic rx_sync, host_deep_src, cfg_rst_hit, wr_cfg, wr_en, wr_sts;
  logic rx_buf, rx_filt, rx_sel, rx_inv, rx_proc, input_level, gpio_in, evt_hit;
  dwgpc_rst_src_t rst_src;
  dwgpc_evt_t evt_mode;
  dwgpc_nbuf_t nbuf;

  // Pin and reset inputs cross in through two flops before anything looks at them
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end
    else
    begin
      meta_q <= {i_rsm_rst_n, i_plt_rst_n, i_deep_sx, i_global_rst, i_host_rst, i_pad_rx};
      sync_q <= meta_q;
    end
  end

  assign rx_sync = sync_q[0];
  assign host_deep_src = sync_q[1] | sync_q[2] | sync_q[3];

  // Field decode
  assign rst_src = dwgpc_rst_src_t'(cfg_q[B_RST_LO+1:B_RST_LO]);
  assign evt_mode = dwgpc_evt_t'(cfg_q[B_EVT_LO+1:B_EVT_LO]);
  assign nbuf = dwgpc_nbuf_t'(cfg_q[B_BUF_LO+1:B_BUF_LO]);

  // Selected reset source; power-good is the block reset itself
  always_comb
  begin
    case (rst_src)
      RS_HOST_DEEP: cfg_rst_hit = host_deep_src;
      RS_PLT: cfg_rst_hit = ~sync_q[4];
      RS_RSM: cfg_rst_hit = ~sync_q[5];
      default: cfg_rst_hit = 1'b0;
    endcase
  end

  // Address decode
  assign wr_cfg = i_reg_wr && (i_reg_addr == OFS_CFG0);
  assign wr_en = i_reg_wr && (i_reg_addr == OFS_EVT_EN);
  assign wr_sts = i_reg_wr && (i_reg_addr == OFS_EVT_STS);

  // Override sits right at the buffer output so inversion still sees it
  assign rx_buf = cfg_q[B_FORCE1] | rx_sync;

  dwgpc_filter #(
    .CYCLES(FILT_CYCLES)
  ) u_filter (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_din(rx_buf),
    .o_dout(rx_filt)
  );

  // Receive chain: filter choice, inversion, then buffer gating
  always_comb
  begin
    rx_sel = cfg_q[B_BYPASS] ? rx_filt : rx_buf;
    rx_inv = rx_sel ^ cfg_q[B_INV];
    rx_proc = rx_inv;
    if (!fsel_q)
    begin
      if (cfg_q[B_RXOFF])
        rx_proc = 1'b0;
    end
    else
    begin
      case (nbuf)
        NB_RX0: rx_proc = 1'b0;
        NB_RX1: rx_proc = 1'b1;
        default: rx_proc = rx_inv;
      endcase
    end
  end

  // Software view: filtered, never inverted, zero while bit 9 is set in either pad mode
  assign input_level = rx_filt & ~cfg_q[B_RXOFF];
  assign gpio_in = ~fsel_q & ~cfg_q[B_RXOFF];

  // Delivery shapes only event triggering, never the state above
  always_comb
  begin
    case (evt_mode)
      EV_LEVEL: evt_hit = rx_proc;
      EV_EDGE: evt_hit = rx_proc & ~prev_q;
      EV_ANY: evt_hit = rx_proc ^ prev_q;
      default: evt_hit = 1'b0;
    endcase
    evt_hit = evt_hit & gpio_in;
  end

  // Ownership steers the event to one status group only
  assign sts_set = {i_other_evt_set, evt_hit & ~i_host_own};
  assign route_vec = {i_other_route_sci, cfg_q[B_R_SCI] & gpio_in};

  // Register file next state; reserved bits masked out on write
  always_comb
  begin
    cfg_d = cfg_q;
    if (cfg_rst_hit)
      cfg_d = {cfg_q[31:B_RST_LO], CFG_RST[B_RST_LO-1:0]};
    else if (wr_cfg)
      cfg_d = i_reg_wdata & CFG_WR_MASK;
    fsel_d = i_func_sel_we ? i_func_sel : fsel_q;
    en_d = wr_en ? i_reg_wdata[NPADS-1:0] : en_q;
    // Set beats a clear in the same cycle
    sts_d = (sts_q & ~(wr_sts ? i_reg_wdata[NPADS-1:0] : PADS_ZERO)) | sts_set;
    prev_d = rx_proc;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_q <= CFG_RST;
      fsel_q <= PAD_MODE_DEF;
      en_q <= PADS_ZERO;
      sts_q <= PADS_ZERO;
      prev_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      fsel_q <= fsel_d;
      en_q <= en_d;
      sts_q <= sts_d;
      prev_q <= prev_d;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb
  begin
    rdata_d = rdata_q;
    ack_d = i_reg_rd;
    if (i_reg_rd)
    begin
      if (i_reg_addr == OFS_CFG0)
      begin
        rdata_d = cfg_q;
        rdata_d[B_R_SMI] = ROUTE_SMI_DEF;
        rdata_d[B_R_NMI] = ROUTE_NMI_DEF;
        rdata_d[B_FSEL] = fsel_q;
        rdata_d[B_RXLVL] = input_level;
      end
      else if (i_reg_addr == OFS_EVT_EN)
        rdata_d = {20'h00000, en_q};
      else if (i_reg_addr == OFS_EVT_STS)
        rdata_d = {20'h00000, sts_q};
      else
        rdata_d = WORD_ZERO;
    end
  end

  // Pad and indication outputs, all registered
  always_comb
  begin
    if (!fsel_q)
    begin
      tx_d = cfg_q[B_TXLVL];
      oe_d = ~cfg_q[B_TXOFF];
      rxen_d = ~cfg_q[B_RXOFF];
    end
    else
    begin
      tx_d = i_native_tx;
      oe_d = i_native_tx_en;
      rxen_d = (nbuf == NB_FUNC) || (nbuf == NB_RXON);
    end
    // Raw choice still honours forced receive levels of the buffer config
    nat_d = cfg_q[B_NAT_SEL] ? rx_proc : rx_buf;
    if (nbuf == NB_RX0)
      nat_d = 1'b0;
    else if (nbuf == NB_RX1)
      nat_d = 1'b1;
    deep_d = host_deep_src;
    gpe_d = |(sts_q & en_q & route_vec);
    int_d = evt_hit & i_host_own;
    irq_d = evt_hit & i_host_own & cfg_q[B_R_IRQ];
    smi_d = evt_hit & ~i_host_own & ROUTE_SMI_DEF;
    nmi_d = evt_hit & ~i_host_own & ROUTE_NMI_DEF;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_q <= WORD_ZERO;
      ack_q <= 1'b0;
      tx_q <= 1'b0;
      oe_q <= 1'b0;
      rxen_q <= 1'b0;
      nat_q <= 1'b0;
      deep_q <= 1'b0;
      gpe_q <= 1'b0;
      int_q <= 1'b0;
      irq_q <= 1'b0;
      smi_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      rxen_q <= rxen_d;
      nat_q <= nat_d;
      deep_q <= deep_d;
      gpe_q <= gpe_d;
      int_q <= int_d;
      irq_q <= irq_d;
      smi_q <= smi_d;
      nmi_q <= nmi_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_ack = ack_q;
  assign o_pad_tx = tx_q;
  assign o_pad_tx_oe = oe_q;
  assign o_pad_rx_en = rxen_q;
  assign o_native_rx = nat_q;
  assign o_host_deep_rst = deep_q;
  assign o_gpe = gpe_q;
  assign o_int_sts_set = int_q;
  assign o_irq = irq_q;
  assign o_smi = smi_q;
  assign o_nmi_sts_set = nmi_q;

  // Checks
  a_gpe_enable_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (en_q == PADS_ZERO) |=> !o_gpe) else $error("event raised with all enables clear");
  a_gpe_route_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_gpe |-> (($past(sts_q) & $past(en_q) & $past(route_vec)) != PADS_ZERO))
    else $error("event raised without route");
  a_pad_rst_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cfg_rst_hit |=> (cfg_q[B_RST_LO-1:0] == CFG_RST[B_RST_LO-1:0])) else $error("selected reset missed");
  a_deep_rst_out: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_host_rst || i_global_rst || i_deep_sx) ##3 1'b1 |-> o_host_deep_rst) else $error("deep reset not driven");
  a_force_one_nat: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (fsel_q && nbuf == NB_FUNC && !cfg_q[B_NAT_SEL] && cfg_q[B_FORCE1]) |=> o_native_rx)
    else $error("force to one not seen");
  a_rx_off_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!fsel_q && cfg_q[B_RXOFF]) |-> (!input_level && !evt_hit) ##1 !o_pad_rx_en)
    else $error("disabled input not held at zero");
  a_tx_gpio_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!fsel_q && !cfg_q[B_TXOFF]) |=> (o_pad_tx == $past(cfg_q[B_TXLVL])) && o_pad_tx_oe)
    else $error("gpio output level wrong");
  a_tx_native_own: assert property (@(posedge i_clk) disable iff (!i_nrst)
    fsel_q |=> (o_pad_tx_oe == $past(i_native_tx_en))) else $error("gpio bits leak into native mode");
  a_sts_set_wins: assert property (@(posedge i_clk) disable iff (!i_nrst)
    sts_set[0] |=> sts_q[0]) else $error("status set lost");
  a_own_steer: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_int_sts_set |-> ($past(i_host_own) && !$past(sts_set[0]))) else $error("ownership steering wrong");
  a_evt_off_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (evt_mode == EV_OFF) |=> !o_int_sts_set && !o_nmi_sts_set) else $error("disabled delivery fired");
endmodule
`default_nettype wire

//--- dwgpc_pin_model.sv
// Pin model: external source and the pad's own output buffer resolved onto one wire
`timescale 1ns/1ps
`default_nettype none
module dwgpc_pin_model (
  input wire logic i_ext_lvl,
  input wire logic i_tx,
  input wire logic i_tx_oe,
  output logic o_pin
);
  // Own buffer wins while enabled; the external source is weak and yields to it
  assign o_pin = i_tx_oe ? i_tx : i_ext_lvl;
endmodule
`default_nettype wire

//--- tb_dwgpc_top.sv
// Self-checking testbench for the deep-well pad configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_dwgpc_top;
  import dwgpc_pkg::*;
  logic i_clk, i_nrst, i_reg_wr, i_reg_rd, i_pad_rx, o_pad_tx, o_pad_tx_oe, o_pad_rx_en;
  logic i_native_tx, i_native_tx_en, o_native_rx, i_func_sel_we, i_func_sel, i_host_own;
  logic i_host_rst, i_global_rst, i_deep_sx, i_plt_rst_n, i_rsm_rst_n, o_host_deep_rst;
  logic o_gpe, o_int_sts_set, o_irq, o_smi, o_nmi_sts_set, o_reg_ack, ext_lvl;
  logic [AW-1:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [NPADS-1:1] i_other_evt_set, i_other_route_sci;
  int err_total, checked, n_int, n_irq, n_side;

  dwgpc_top i_dwgpc_top (.*);
  dwgpc_pin_model i_dwgpc_pin_model (.i_ext_lvl(ext_lvl), .i_tx(o_pad_tx), .i_tx_oe(o_pad_tx_oe), .o_pin(i_pad_rx));

  // Free-running 100 MHz clock
  initial
  begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  // Pulse tallies, taken at the rising edge where registered outputs are settled
  always @(posedge i_clk)
  begin
    if (o_int_sts_set !== 1'h0) n_int++;
    if (o_irq !== 1'h0) n_irq++;
    if ((o_smi | o_nmi_sts_set) !== 1'h0) n_side++;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // One-cycle write strobe; no acknowledge exists for writes
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'h1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'h0;
  endtask

  // Read with a bounded wait for the acknowledge, then compare
  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    d = 32'hffff_ffff;
    @(negedge i_clk);
    i_reg_rd = 1'h1;
    i_reg_addr = a;
    for (int n = 0; n < 4; n++)
    begin
      @(negedge i_clk);
      i_reg_rd = 1'h0;
      if (o_reg_ack === 1'h1)
      begin
        d = o_reg_rdata;
        break;
      end
    end
    chk(d, exp);
  endtask

  // Settle a config with the pin at one level, then count pulses after moving it
  task automatic ev(input logic [31:0] c, input logic a, input logic b);
    ext_lvl = a;
    wr(OFS_CFG0, c);
    cyc(8);
    n_int = 0;
    n_irq = 0;
    n_side = 0;
    ext_lvl = b;
    cyc(10);
  endtask

  task automatic t_regs();
    rdc(OFS_CFG0, 32'h0400_0300);
    rdc(OFS_EVT_EN, 32'h0000_0000);
    chk({30'h0, o_pad_tx_oe, o_pad_rx_en}, 32'h0);
    wr(OFS_CFG0, 32'hffff_ffff);
    rdc(OFS_CFG0, 32'hf7f8_0301);
    wr(OFS_EVT_EN, 32'hffff_ffff);
    rdc(OFS_EVT_EN, 32'h0000_0fff);
    wr(12'h7f0, 32'hffff_ffff);
    rdc(12'h7f0, 32'h0000_0000);
    wr(OFS_EVT_EN, 32'h0000_0000);
  endtask

  task automatic t_out();
    wr(OFS_CFG0, 32'h0000_0201);
    cyc(2);
    chk({30'h0, o_pad_tx_oe, o_pad_tx}, 32'h3);
    wr(OFS_CFG0, 32'h0000_0200);
    cyc(2);
    chk({30'h0, o_pad_tx_oe, o_pad_tx}, 32'h2);
    wr(OFS_CFG0, 32'h0000_0301);
    cyc(2);
    chk({31'h0, o_pad_tx_oe}, 32'h0);
  endtask

  // Native mode: GPIO bits ignored, field 22:21 and bit 29 steer the function side
  task automatic t_native();
    i_native_tx_en = 1'h1;
    i_native_tx = 1'h1;
    i_func_sel = 1'h1;
    i_func_sel_we = 1'h1;
    cyc(1);
    i_func_sel_we = 1'h0;
    wr(OFS_CFG0, 32'h0000_0300);
    cyc(2);
    chk({30'h0, o_pad_tx_oe, o_pad_tx}, 32'h3);
    rdc(OFS_CFG0, 32'h0000_0700);
    i_native_tx_en = 1'h0;
    ev(32'h0020_0000, 1'h1, 1'h1);
    chk({30'h0, o_pad_rx_en, o_native_rx}, 32'h0);
    ev(32'h0040_0000, 1'h0, 1'h0);
    chk({30'h0, o_pad_rx_en, o_native_rx}, 32'h1);
    ev(32'h0060_0000, 1'h1, 1'h1);
    chk({30'h0, o_pad_rx_en, o_native_rx}, 32'h3);
    ev(32'h1000_0000, 1'h0, 1'h0);
    chk({31'h0, o_native_rx}, 32'h1);
    ev(32'h2080_0000, 1'h1, 1'h1);
    chk({31'h0, o_native_rx}, 32'h0);
    ev(32'h0080_0000, 1'h1, 1'h1);
    chk({31'h0, o_native_rx}, 32'h1);
    i_func_sel = 1'h0;
    i_func_sel_we = 1'h1;
    cyc(1);
    i_func_sel_we = 1'h0;
  endtask

  // Driver-owned pad: interrupt path shaping by delivery, inversion, force and gates
  task automatic t_events();
    i_host_own = 1'h1;
    ev(32'h0010_0100, 1'h0, 1'h1);
    chk({30'h0, n_int > 0, n_irq == n_int}, 32'h3);
    rdc(OFS_CFG0, 32'h0010_0102);
    ev(32'h0090_0100, 1'h1, 1'h1);
    chk(n_int, 32'h0);
    rdc(OFS_CFG0, 32'h0090_0102);
    ev(32'h0410_0100, 1'h0, 1'h1);
    chk(n_int, 32'h0);
    ev(32'h0210_0100, 1'h0, 1'h1);
    chk(n_int, 32'h1);
    ev(32'h0210_0100, 1'h1, 1'h0);
    chk(n_int, 32'h0);
    ev(32'h0610_0100, 1'h1, 1'h0);
    chk(n_int, 32'h1);
    ev(32'h0000_0100, 1'h1, 1'h1);
    chk({30'h0, n_int > 0, n_irq > 0}, 32'h2);
    // One-cycle glitch passes unfiltered, is swallowed when filtered
    for (int f = 0; f < 2; f++)
    begin
      ev({7'h0, f[0], 24'h10_0100}, 1'h0, 1'h0);
      ext_lvl = 1'h1;
      cyc(1);
      ext_lvl = 1'h0;
      cyc(8);
      chk(n_int, {31'h0, ~f[0]});
    end
    ev(32'h0010_0300, 1'h1, 1'h1);
    chk(n_int, 32'h0);
    rdc(OFS_CFG0, 32'h0010_0300);
    ev(32'h1010_0100, 1'h0, 1'h0);
    chk({31'h0, n_int > 0}, 32'h1);
    rdc(OFS_CFG0, 32'h1010_0102);
    rdc(OFS_EVT_STS, 32'h0000_0000);
  endtask

  // Firmware-owned pad: sticky status, clear by one, enable and route gating
  task automatic t_gpe();
    i_host_own = 1'h0;
    wr(OFS_EVT_EN, 32'h0000_0001);
    ev(32'h0008_0100, 1'h0, 1'h1);
    chk({29'h0, o_gpe, n_int > 0, n_side > 0}, 32'h4);
    ext_lvl = 1'h0;
    cyc(8);
    rdc(OFS_EVT_STS, 32'h0000_0001);
    wr(OFS_EVT_STS, 32'h0000_0001);
    rdc(OFS_EVT_STS, 32'h0000_0000);
    chk({31'h0, o_gpe}, 32'h0);
    ev(32'h0000_0100, 1'h0, 1'h1);
    rdc(OFS_EVT_STS, 32'h0000_0001);
    chk({31'h0, o_gpe}, 32'h0);
    wr(OFS_EVT_EN, 32'h0000_0000);
    wr(OFS_CFG0, 32'h0008_0100);
    cyc(3);
    chk({31'h0, o_gpe}, 32'h0);
    // Pad 5 reaches the event line through its own enable and route
    i_other_route_sci = 11'h010;
    wr(OFS_EVT_EN, 32'h0000_0020);
    i_other_evt_set = 11'h010;
    cyc(1);
    i_other_evt_set = 11'h000;
    cyc(2);
    chk({31'h0, o_gpe}, 32'h1);
    rdc(OFS_EVT_STS, 32'h0000_0021);
    ext_lvl = 1'h0;
  endtask

  // Reset source selection and deep reset causes
  task automatic t_rst();
    for (int s = 1; s < 4; s++)
    begin
      wr(OFS_CFG0, {s[1:0], 30'h0000_0201});
      i_host_rst = (s == 1);
      i_plt_rst_n = (s != 2);
      i_rsm_rst_n = (s != 3);
      cyc(6);
      i_host_rst = 1'h0;
      i_plt_rst_n = 1'h1;
      i_rsm_rst_n = 1'h1;
      cyc(6);
      rdc(OFS_CFG0, {s[1:0], 30'h0400_0300});
    end
    wr(OFS_CFG0, 32'h0000_0201);
    i_plt_rst_n = 1'h0;
    i_rsm_rst_n = 1'h0;
    cyc(6);
    chk({31'h0, o_host_deep_rst}, 32'h0);
    i_plt_rst_n = 1'h1;
    i_rsm_rst_n = 1'h1;
    for (int c = 0; c < 3; c++)
    begin
      {i_deep_sx, i_global_rst, i_host_rst} = 3'h1 << c;
      cyc(6);
      chk({31'h0, o_host_deep_rst}, 32'h1);
      {i_deep_sx, i_global_rst, i_host_rst} = 3'h0;
      cyc(6);
      chk({31'h0, o_host_deep_rst}, 32'h0);
    end
    rdc(OFS_CFG0, 32'h0000_0201);
  endtask

  // Watchdog sized well beyond the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    {i_nrst, i_reg_wr, i_reg_rd, i_native_tx, i_native_tx_en, i_func_sel_we, i_func_sel} = 7'h0;
    {i_host_own, i_host_rst, i_global_rst, i_deep_sx, ext_lvl} = 5'h0;
    {i_plt_rst_n, i_rsm_rst_n} = 2'h3;
    i_reg_addr = 12'h000;
    i_reg_wdata = 32'h0000_0000;
    i_other_evt_set = 11'h000;
    i_other_route_sci = 11'h000;
    repeat (3) @(negedge i_clk);
    i_nrst = 1'h1;
    t_regs();
    t_out();
    t_native();
    t_events();
    t_gpe();
    t_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
